// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import upc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    upc_bus_req_t bus_req = '0;
    logic [31:0] rdata;
    logic [1:0] line_raw;
    logic [1:0] line_cmd = LS_SE0;
    logic link_suspend = 1'b0;
    upc_phy_ctl_t phy_ctl;
    logic [1:0] line_state_filt;
    logic resume_wake;
    logic irq;
    int n_errors = 0;
    int compares = 0;

    always #50 clock = ~clock;

    upc_top upc_top_inst (
        .clock(clock), .resetn(resetn), .bus_req(bus_req),
        .rdata(rdata), .line_state_raw(line_raw),
        .link_suspend(link_suspend), .phy_ctl(phy_ctl),
        .line_state_filt(line_state_filt), .resume_wake(resume_wake),
        .irq(irq)
    );
    upc_phy_model upc_phy_model_inst (
        .clock(clock), .resetn(resetn), .line_cmd(line_cmd),
        .phy_ctl(phy_ctl), .line_state_raw(line_raw)
    );

    // ----------------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic line(input logic [1:0] ls, input int n);
        @(posedge clock);
        line_cmd <= ls;
        cyc(n);
        #1;
    endtask : line

    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Whole run is well under 1000 cycles
    initial begin
        #500000;
        n_errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        cyc(6);
        resetn <= 1'b1;
        rd(OFF_PWR, 32'h0);
        rd(OFF_PHY, 32'h0);
        check(32'(phy_ctl), 32'h0);
        $display("test reset done");

        wr(OFF_PWR, 32'hffff_ffff);
        rd(OFF_PWR, 32'h0000_01ff);
        wr(OFF_PWR, 32'h0000_00a5);
        rd(OFF_PWR, 32'h0000_00a5);
        rd(8'h50, 32'h0);
        $display("test power done");

        // Writing ones to the sticky flags must not set them
        wr(OFF_PHY, 32'hffff_ffff);
        rd(OFF_PHY, 32'h0004_0ff0);
        check(32'(phy_ctl), 32'h1f);
        wr(OFF_PHY, 32'h0000_0050);
        check(32'(phy_ctl), 32'h14);
        $display("test config done");

        // Filter with 16 stable cycles; a short pulse never passes
        wr(OFF_PHY, 32'h0000_0400);
        line(LS_J, 14);
        check(32'(line_state_filt), 32'(LS_SE0));
        cyc(12);
        #1;
        check(32'(line_state_filt), 32'(LS_J));
        line(LS_K, 10);
        line(LS_J, 4);
        check(32'(line_state_filt), 32'(LS_J));
        cyc(26);
        #1;
        check(32'(line_state_filt), 32'(LS_J));
        $display("test filter done");

        // Hardware resume on a bus reset
        wr(OFF_PHY, 32'h0000_0280);
        @(posedge clock);
        link_suspend <= 1'b1;
        cyc(3);
        line(LS_SE0, 14);
        check(32'(resume_wake), 32'h1);
        rd(OFF_PHY, 32'h0000_2280);
        rd(OFF_LINE, 32'h0000_0004);
        check(32'(irq), 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        cyc(1);
        #1;
        check(32'(irq), 32'h1);
        rd(OFF_IRQ_MASK, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        cyc(1);
        #1;
        check(32'(irq), 32'h0);
        rd(OFF_IRQ_STAT, 32'h4);
        @(posedge clock);
        link_suspend <= 1'b0;
        cyc(2);
        #1;
        check(32'(resume_wake), 32'h0);
        wr(OFF_PHY, 32'h0000_0280);
        rd(OFF_PHY, 32'h0000_0280);
        $display("test reset resume done");

        // Hardware resume on K signalling
        line(LS_J, 14);
        @(posedge clock);
        link_suspend <= 1'b1;
        cyc(3);
        line(LS_K, 14);
        check(32'(resume_wake), 32'h1);
        rd(OFF_PHY, 32'h0000_1280);
        @(posedge clock);
        link_suspend <= 1'b0;
        wr(OFF_PHY, 32'h0000_0280);
        rd(OFF_PHY, 32'h0000_0280);
        $display("test k resume done");

        // Polled mode: no automatic resume, software reads line state
        wr(OFF_PHY, 32'h0000_0200);
        line(LS_J, 14);
        rd(OFF_LINE, 32'h0000_0001);
        @(posedge clock);
        link_suspend <= 1'b1;
        cyc(3);
        line(LS_SE0, 14);
        check(32'(resume_wake), 32'h0);
        rd(OFF_LINE, 32'h0);
        rd(OFF_PHY, 32'h0000_0200);
        @(posedge clock);
        link_suspend <= 1'b0;
        $display("test polled done");
        results();
    end
endmodule : tb_top

// file: bench/upc_phy_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Transceiver line model
// ----------------------------------------------------------------
// The line state comes from an output flop, so it never changes on
// the edge that the bench uses to ask for a new state.
module upc_phy_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] line_cmd,
    input upc_pkg::upc_phy_ctl_t phy_ctl,
    output logic [1:0] line_state_raw
);
    import upc_pkg::*;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            line_state_raw <= LS_SE0;
        end else begin
            line_state_raw <= line_cmd;
        end
    end
endmodule : upc_phy_model

// file: hw/upc_line_filter.sv
`timescale 1ns/100ps
module upc_line_filter #(
    parameter int CNT_W = 16,
    parameter int LOG_W = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] line_in,
    input wire logic [LOG_W-1:0] log2_cycles,
    output logic [1:0] line_out,
    output logic changed
);
    import upc_pkg::*;

    typedef struct packed {
        logic [1:0] cand;
        logic [CNT_W-1:0] cnt;
        logic [1:0] out;
        logic chg;
    } upc_filt_st_t;

    upc_filt_st_t st;
    upc_filt_st_t next_st;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] seen;

    assign target = CNT_W'(1) << log2_cycles;
    assign seen = (line_in != st.cand) ? CNT_W'(1) : st.cnt + CNT_W'(1);

    // ----------------------------------------------------------------
    // Hold a change until it has stood long enough
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.chg = 1'b0;
        next_st.cand = line_in;
        if (line_in == st.out) begin
            next_st.cnt = '0;
        end else if (seen >= target) begin
            next_st.out = line_in;
            next_st.chg = 1'b1;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = seen;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign line_out = st.out;
    assign changed = st.chg;

    // Helper: cycles the input has held its present value
    logic [CNT_W:0] stable;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stable <= '0;
        end else if (line_in != st.cand) begin
            stable <= (CNT_W+1)'(1);
        end else if (stable[CNT_W] == 1'b0) begin
            stable <= stable + (CNT_W+1)'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_filter_value: assert property (
        $changed(line_out) |-> line_out == $past(line_in))
        else $error("filtered line took a value not seen on input");
    chk_filter_hold: assert property (
        $changed(line_out) && $stable(log2_cycles)
            |-> stable >= {1'b0, $past(target)})
        else $error("line change passed before hold time");

endmodule : upc_line_filter

// file: hw/upc_resume_det.sv
`timescale 1ns/100ps
module upc_resume_det (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] line_filt,
    input wire logic hw_resume_en,
    input wire logic link_suspend,
    output logic se0_evt,
    output logic k_evt,
    output logic wake
);
    import upc_pkg::*;

    typedef enum logic [1:0] {RD_IDLE, RD_SUSP, RD_WAKE} upc_rd_state_t;

    typedef struct packed {
        upc_rd_state_t state;
        logic se0;
        logic k;
        logic wake;
    } upc_rd_st_t;

    upc_rd_st_t st;
    upc_rd_st_t next_st;

    // ----------------------------------------------------------------
    // Suspend watcher
    // ----------------------------------------------------------------
    // Without the enable, software polls the filtered line instead
    always_comb begin
        next_st = st;
        next_st.se0 = 1'b0;
        next_st.k = 1'b0;
        case (st.state)
            RD_IDLE: begin
                next_st.wake = 1'b0;
                if (link_suspend) begin
                    next_st.state = RD_SUSP;
                end
            end
            RD_SUSP: begin
                if (!link_suspend) begin
                    next_st.state = RD_IDLE;
                end else if (hw_resume_en && line_filt == LS_SE0) begin
                    next_st.se0 = 1'b1;
                    next_st.wake = 1'b1;
                    next_st.state = RD_WAKE;
                end else if (hw_resume_en && line_filt == LS_K) begin
                    next_st.k = 1'b1;
                    next_st.wake = 1'b1;
                    next_st.state = RD_WAKE;
                end
            end
            RD_WAKE: begin
                if (!link_suspend) begin
                    next_st.wake = 1'b0;
                    next_st.state = RD_IDLE;
                end
            end
            default: begin
                next_st = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign se0_evt = st.se0;
    assign k_evt = st.k;
    assign wake = st.wake;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_auto_se0: assert property (
        st.state == RD_SUSP && link_suspend && hw_resume_en
            && line_filt == LS_SE0 |=> se0_evt && wake && !k_evt)
        else $error("SE0 during suspend did not wake the link");
    chk_polled_only: assert property (
        !hw_resume_en |=> !se0_evt && !k_evt)
        else $error("auto resume happened with hardware resume off");

endmodule : upc_resume_det

// file: hw/upc_top.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module upc_top #(
    parameter int FILT_CNT_W = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input upc_pkg::upc_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic [1:0] line_state_raw,
    input wire logic link_suspend,
    output upc_pkg::upc_phy_ctl_t phy_ctl,
    output logic [1:0] line_state_filt,
    output logic resume_wake,
    output logic irq
);
    import upc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] ls_meta;
        logic [1:0] ls_sync;
        logic [PWR_W-1:0] pwr;
        logic pd_dis;
        logic se0_flag;
        logic k_flag;
        logic [PHY_FILT_W-1:0] filt_log2;
        logic hw_susp;
        logic [PHY_CONF_W-1:0] conf;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic irq;
    } upc_top_st_t;

    upc_top_st_t st;
    upc_top_st_t next_st;

    logic [1:0] filt_line;
    logic filt_chg;
    logic se0_evt;
    logic k_evt;
    logic wake;

    logic wr_pwr;
    logic wr_phy;
    logic wr_stat;
    logic wr_mask;
    logic [IRQ_W-1:0] events;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        hit = (a == off);
    endfunction : hit

    function automatic logic [31:0] reg_read(
        input logic [ADDR_W-1:0] a,
        input upc_top_st_t s,
        input logic [1:0] ls,
        input logic wk
    );
        logic [31:0] w;
        w = RST_WORD;
        if (hit(a, OFF_PWR)) begin
            w[PWR_DATA_LSB +: PWR_W] = s.pwr;
        end else if (hit(a, OFF_PHY)) begin
            w[PHY_PD_DIS_BIT] = s.pd_dis;
            w[PHY_SE0_BIT] = s.se0_flag;
            w[PHY_K_BIT] = s.k_flag;
            w[PHY_FILT_LSB +: PHY_FILT_W] = s.filt_log2;
            w[PHY_HWSUSP_BIT] = s.hw_susp;
            w[PHY_CONF_LSB +: PHY_CONF_W] = s.conf;
        end else if (hit(a, OFF_IRQ_STAT)) begin
            w[IRQ_W-1:0] = s.irq_stat;
        end else if (hit(a, OFF_IRQ_MASK)) begin
            w[IRQ_W-1:0] = s.irq_mask;
        end else if (hit(a, OFF_LINE)) begin
            w[1:0] = ls;
            w[LINE_WAKE_BIT] = wk;
        end
        reg_read = w;
    endfunction : reg_read

    assign wr_pwr = bus_req.wr && hit(bus_req.addr, OFF_PWR);
    assign wr_phy = bus_req.wr && hit(bus_req.addr, OFF_PHY);
    assign wr_stat = bus_req.wr && hit(bus_req.addr, OFF_IRQ_STAT);
    assign wr_mask = bus_req.wr && hit(bus_req.addr, OFF_IRQ_MASK);

    assign events = {filt_chg, k_evt, se0_evt};

    // ----------------------------------------------------------------
    // Line filter and resume watcher
    // ----------------------------------------------------------------
    upc_line_filter #(
        .CNT_W(FILT_CNT_W),
        .LOG_W(PHY_FILT_W)
    ) u_filter (
        .clock(clock),
        .resetn(resetn),
        .line_in(st.ls_sync),
        .log2_cycles(st.filt_log2),
        .line_out(filt_line),
        .changed(filt_chg)
    );

    upc_resume_det u_resume (
        .clock(clock),
        .resetn(resetn),
        .line_filt(filt_line),
        .hw_resume_en(st.hw_susp),
        .link_suspend(link_suspend),
        .se0_evt(se0_evt),
        .k_evt(k_evt),
        .wake(wake)
    );

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Raw line pins come from the transceiver domain
        next_st.ls_meta = line_state_raw;
        next_st.ls_sync = st.ls_meta;

        if (wr_pwr) begin
            next_st.pwr = bus_req.wdata[PWR_DATA_LSB +: PWR_W];
        end

        if (wr_phy) begin
            next_st.pd_dis = bus_req.wdata[PHY_PD_DIS_BIT];
            next_st.filt_log2 =
                bus_req.wdata[PHY_FILT_LSB +: PHY_FILT_W];
            next_st.hw_susp = bus_req.wdata[PHY_HWSUSP_BIT];
            next_st.conf = bus_req.wdata[PHY_CONF_LSB +: PHY_CONF_W];
            // Writing one leaves a flag alone; only zero clears it
            next_st.se0_flag = st.se0_flag & bus_req.wdata[PHY_SE0_BIT];
            next_st.k_flag = st.k_flag & bus_req.wdata[PHY_K_BIT];
        end
        // A new resume beats a clear in the same cycle
        next_st.se0_flag = next_st.se0_flag | se0_evt;
        next_st.k_flag = next_st.k_flag | k_evt;

        if (wr_mask) begin
            next_st.irq_mask = bus_req.wdata[IRQ_W-1:0];
        end
        if (wr_stat) begin
            next_st.irq_stat = st.irq_stat & ~bus_req.wdata[IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | events;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // Read data live for exactly one cycle, zero otherwise
        if (bus_req.rd) begin
            next_st.rdata = reg_read(bus_req.addr, st, filt_line, wake);
        end else begin
            next_st.rdata = RST_WORD;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = st.rdata;
    assign irq = st.irq;
    assign phy_ctl.transceiver_config_pins = st.conf;
    assign phy_ctl.usb_port_a_pd_dis = st.pd_dis;
    assign phy_ctl.usb_port_b_pd_dis = st.pd_dis;
    assign line_state_filt = filt_line;
    assign resume_wake = wake;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_phy_wr;
        bus_req.wr && bus_req.addr == OFF_PHY;
    endsequence

    sequence s_pwr_rd;
        bus_req.rd && bus_req.addr == OFF_PWR;
    endsequence

    sequence s_pwr_wr;
        bus_req.wr && bus_req.addr == OFF_PWR;
    endsequence

    sequence s_phy_rd;
        bus_req.rd && bus_req.addr == OFF_PHY;
    endsequence

    chk_conf_pins: assert property (
        s_phy_wr |=> phy_ctl.transceiver_config_pins
            == $past(bus_req.wdata[PHY_CONF_LSB +: PHY_CONF_W]))
        else $error("config pins did not follow the write");

    chk_pulldown_ports: assert property (
        s_phy_wr |=> phy_ctl.usb_port_a_pd_dis
            == $past(bus_req.wdata[PHY_PD_DIS_BIT])
            && phy_ctl.usb_port_b_pd_dis == phy_ctl.usb_port_a_pd_dis)
        else $error("pulldown disable did not follow the write");

    chk_se0_sticky: assert property (
        se0_evt |=> st.se0_flag [*2] or (st.se0_flag ##1 $fell(st.se0_flag)))
        else $error("SE0 resume flag not set after event");

    chk_k_clear: assert property (
        s_phy_wr and !bus_req.wdata[PHY_K_BIT] and !k_evt |=> !st.k_flag)
        else $error("K resume flag not cleared by zero write");

    chk_pwr_read: assert property (
        s_pwr_rd ##1 1'b1 |-> rdata[31:PWR_W] == '0
            && rdata[PWR_W-1:0] == $past(st.pwr))
        else $error("power word read back wrong");

    chk_irq_level: assert property (
        irq == |(st.irq_stat & st.irq_mask))
        else $error("interrupt line disagrees with status");

    // ----------------------------------------------------------------
    // Field capture and read-back
    // ----------------------------------------------------------------
    chk_pwr_write: assert property (
        s_pwr_wr |=> st.pwr == $past(bus_req.wdata[PWR_DATA_LSB +: PWR_W]))
        else $error("power word did not take the write");

    chk_filt_field: assert property (
        s_phy_wr |=> st.filt_log2
            == $past(bus_req.wdata[PHY_FILT_LSB +: PHY_FILT_W]))
        else $error("filter length did not take the write");

    chk_susp_field: assert property (
        s_phy_wr |=> st.hw_susp == $past(bus_req.wdata[PHY_HWSUSP_BIT]))
        else $error("suspend handling bit did not take the write");

    chk_mask_write: assert property (
        wr_mask |=> st.irq_mask == $past(bus_req.wdata[IRQ_W-1:0]))
        else $error("interrupt mask did not take the write");

    // Reserved bits 3:0 and 31:19 must read zero, even beside live flags
    chk_phy_read: assert property (
        s_phy_rd |=> rdata[PHY_SE0_BIT] == $past(st.se0_flag)
            && rdata[PHY_K_BIT] == $past(st.k_flag)
            && rdata[PHY_CONF_LSB +: PHY_CONF_W] == $past(st.conf)
            && rdata[PHY_CONF_LSB-1:0] == '0
            && rdata[31:PHY_PD_DIS_BIT+1] == '0)
        else $error("control word read back wrong");

    // A stray word on rdata would look like a second answer
    chk_rdata_idle: assert property (
        !bus_req.rd |=> rdata == '0)
        else $error("read data stood outside a read");

    // ----------------------------------------------------------------
    // Resume flags and status
    // ----------------------------------------------------------------
    chk_k_sticky: assert property (
        k_evt |=> st.k_flag)
        else $error("K resume flag not set after event");

    chk_se0_clear: assert property (
        wr_phy && !bus_req.wdata[PHY_SE0_BIT] && !se0_evt |=> !st.se0_flag)
        else $error("SE0 resume flag not cleared by zero write");

    chk_flags_hold: assert property (
        !wr_phy && !se0_evt && !k_evt |=> $stable(st.se0_flag)
            && $stable(st.k_flag))
        else $error("resume flag moved with no event or write");

    chk_stat_wins: assert property (
        events != '0 |=> (st.irq_stat & $past(events)) == $past(events))
        else $error("event lost to a status clear");

    chk_stat_clear: assert property (
        wr_stat && bus_req.wdata[IRQ_SE0] && !events[IRQ_SE0]
            |=> !st.irq_stat[IRQ_SE0])
        else $error("status bit not cleared by a one write");

    // ----------------------------------------------------------------
    // Line path
    // ----------------------------------------------------------------
    chk_line_sync: assert property (
        $past(resetn, 2) |-> st.ls_sync == $past(line_state_raw, 2))
        else $error("line pins not passed through two flops");

    chk_wake_enabled: assert property (
        $rose(resume_wake) |-> $past(st.hw_susp))
        else $error("wake raised with hardware resume off");

endmodule : upc_top

// file: pkg/upc_pkg.sv
package upc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_PWR = 8'h3c;
    localparam logic [ADDR_W-1:0] OFF_PHY = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_LINE = 8'h4c;
    localparam logic [31:0] RST_WORD = 32'h0;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int PWR_DATA_LSB = 0;
    localparam int PWR_W = 9;
    localparam int PHY_PD_DIS_BIT = 18;
    localparam int PHY_SE0_BIT = 13;
    localparam int PHY_K_BIT = 12;
    localparam int PHY_FILT_LSB = 8;
    localparam int PHY_FILT_W = 4;
    localparam int PHY_HWSUSP_BIT = 7;
    localparam int PHY_CONF_LSB = 4;
    localparam int PHY_CONF_W = 3;
    localparam int IRQ_SE0 = 0;
    localparam int IRQ_K = 1;
    localparam int IRQ_LINE = 2;
    localparam int IRQ_W = 3;
    localparam int LINE_WAKE_BIT = 2;

    // ----------------------------------------------------------------
    // Line states
    // ----------------------------------------------------------------
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } upc_bus_req_t;

    typedef struct packed {
        logic [PHY_CONF_W-1:0] transceiver_config_pins;
        logic usb_port_a_pd_dis;
        logic usb_port_b_pd_dis;
    } upc_phy_ctl_t;

endpackage : upc_pkg
